// ---- ivs_lookup.sv ----
/*
  Ingress VLAN and spanning-tree lookup stage with its tables, port masks,
  sticky diagnostics and an AHB-Lite register slave.
  Assumes requests arrive synchronous to mclk; results appear one cycle later.
*/
`default_nettype none
// What this block does
// - VLAN entry carries 9-bit router leg out
// - VLAN entry has 7-bit spanning-tree pointer
// - VLAN entry 13-bit database id is output
// - 65-bit member mask plus unused 16-bit group
// - spanning-tree table, 66 entries, fwd/learn bits
// - index VID plus extension times 4096, chain
// - lookup off: default entry, all-ones masks
// - CPU-injected frames bypass, results unchanged
// - CPU and virtual ports: no learn, no checks except secure forwarding
// - port forward off clears fwd, sticky
// - port learn off clears learn, sticky
// - empty member mask sets invalid sticky
// - ingress filter miss clears both, skips rest
// - spanning-tree fwd bit: discard or allowed sticky
// - VLAN learn-disable, then tree learn bit stickies
// - private VLAN port type, isolated wins
// - isolated source keeps only promiscuous ports
// - community source drops isolated ports
// - mask AND port enable AND tree fwd
// - egress VID is ingress VID; egress database id from multicast bit
// - secure forwarding needs known source MAC
module ivs_lookup (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ivs_pkg::ivs_req_t req,
  output logic reqReady,
  output ivs_pkg::ivs_resp_t resp
);
  // ****************************************************************
  // storage
  // ****************************************************************
  ivs_pkg::ivs_vlan_entry_t vlanTbl [ivs_pkg::VLAN_DEPTH];
  ivs_pkg::ivs_mstp_entry_t mstpTbl [ivs_pkg::MSTP_DEPTH];
  logic [31:0] stage_q [ivs_pkg::STAGE_WORDS];
  logic [64:0] mask_q [ivs_pkg::MASK_BANKS];
  logic vlanEna_q;
  logic [12:0] tblAddr_q;
  logic [ivs_pkg::NSTICKY-1:0] sticky_q;
  logic [ivs_pkg::NSTICKY-1:0] sticky_d;
  ivs_pkg::ivs_resp_t resp_q;
  ivs_pkg::ivs_resp_t resp_d;
  logic reqReady_q;

  // ****************************************************************
  // bus address phase capture
  // ****************************************************************
  logic [7:0] dAddr_q;
  logic dWrite_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdMux;
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] aOff = {haddr[7:2], 2'h0};
  wire wrCtrl = dWrite_q & (dAddr_q == ivs_pkg::REG_CTRL);
  wire wrSticky = dWrite_q & (dAddr_q == ivs_pkg::REG_STICKY);
  wire wrAddr = dWrite_q & (dAddr_q == ivs_pkg::REG_TBL_ADDR);
  wire wrCmd = dWrite_q & (dAddr_q == ivs_pkg::REG_TBL_CMD);
  wire cmdWrVlan = wrCmd & hwdata[ivs_pkg::CMD_WR_VLAN_BIT];
  wire cmdWrMstp = wrCmd & hwdata[ivs_pkg::CMD_WR_MSTP_BIT];
  wire cmdRdVlan = wrCmd & hwdata[ivs_pkg::CMD_RD_VLAN_BIT];
  wire cmdRdMstp = wrCmd & hwdata[ivs_pkg::CMD_RD_MSTP_BIT];
  wire [159:0] stageFlat = {stage_q[4], stage_q[3], stage_q[2], stage_q[1], stage_q[0]};
  wire vlanAddrOk = tblAddr_q < 13'(ivs_pkg::VLAN_DEPTH);
  wire mstpAddrOk = tblAddr_q < 13'(ivs_pkg::MSTP_DEPTH);
  wire [159:0] vlanRdFlat = vlanAddrOk ? {44'h0, vlanTbl[tblAddr_q]} : 160'h0;
  wire [159:0] mstpRdFlat = mstpAddrOk ? {30'h0, mstpTbl[tblAddr_q[6:0]]} : 160'h0;
  wire [7:0] stageRel = aOff - ivs_pkg::REG_STAGE_BASE;
  wire [7:0] maskRel = aOff - ivs_pkg::REG_MASK_BASE;
  wire inStage = (aOff >= ivs_pkg::REG_STAGE_BASE) && (stageRel < 8'(4 * ivs_pkg::STAGE_WORDS));
  wire inMask = (aOff >= ivs_pkg::REG_MASK_BASE) &&
    (maskRel < 8'(ivs_pkg::MASK_BANK_STRIDE * ivs_pkg::MASK_BANKS)) &&
    (maskRel[3:2] < 2'(ivs_pkg::MASK_WORDS));
  wire [95:0] maskRdWide = {31'h0, mask_q[maskRel[6:4]]};

  // unmapped offsets read as zero and ignore writes
  always_comb begin
    rdMux = 32'h0;
    if (aOff == ivs_pkg::REG_CTRL) begin
      rdMux[ivs_pkg::CTRL_VLAN_ENA_BIT] = vlanEna_q;
    end else if (aOff == ivs_pkg::REG_STICKY) begin
      rdMux[ivs_pkg::NSTICKY-1:0] = sticky_q;
    end else if (aOff == ivs_pkg::REG_TBL_ADDR) begin
      rdMux[12:0] = tblAddr_q;
    end else if (inStage) begin
      rdMux = stage_q[stageRel[4:2]];
    end else if (inMask) begin
      rdMux = maskRdWide[maskRel[3:2]*32 +: 32];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dAddr_q <= 8'h00;
      dWrite_q <= 1'b0;
      hrdata_q <= 32'h0;
    end else begin
      dWrite_q <= addrPhase & hwrite;
      if (addrPhase) begin
        dAddr_q <= aOff;
      end
      if (addrPhase & ~hwrite) begin
        hrdata_q <= rdMux;
      end
    end
  end

  // zero-wait slave, always OKAY
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = hrdata_q;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vlanEna_q <= ivs_pkg::CTRL_VLAN_ENA_RST;
      tblAddr_q <= 13'h0;
    end else begin
      if (wrCtrl) begin
        vlanEna_q <= hwdata[ivs_pkg::CTRL_VLAN_ENA_BIT];
      end
      if (wrAddr) begin
        tblAddr_q <= hwdata[12:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < ivs_pkg::MASK_BANKS; g++) begin : gBank
      wire [7:0] bankBase = 8'(ivs_pkg::REG_MASK_BASE + g * ivs_pkg::MASK_BANK_STRIDE);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          mask_q[g] <= ivs_pkg::MASK_RST;
        end else if (dWrite_q && dAddr_q == bankBase) begin
          mask_q[g][31:0] <= hwdata;
        end else if (dWrite_q && dAddr_q == bankBase + 8'h04) begin
          mask_q[g][63:32] <= hwdata;
        end else if (dWrite_q && dAddr_q == bankBase + 8'h08) begin
          mask_q[g][64] <= hwdata[0];
        end
      end
    end
  endgenerate

  // staging words: software fills them, or a read command loads them from a table
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ivs_pkg::STAGE_WORDS; i++) begin
        stage_q[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < ivs_pkg::STAGE_WORDS; i++) begin
        if (cmdRdVlan) begin
          stage_q[i] <= vlanRdFlat[i*32 +: 32];
        end else if (cmdRdMstp) begin
          stage_q[i] <= mstpRdFlat[i*32 +: 32];
        end else if (dWrite_q && dAddr_q == 8'(ivs_pkg::REG_STAGE_BASE + 4 * i)) begin
          stage_q[i] <= hwdata;
        end
      end
    end
  end

  // tables are plain storage with no reset; software loads them before enabling lookup
  always_ff @(posedge mclk) begin
    if (cmdWrVlan && vlanAddrOk) begin
      vlanTbl[tblAddr_q] <= ivs_pkg::ivs_vlan_entry_t'(stageFlat[115:0]);
    end
    if (cmdWrMstp && mstpAddrOk) begin
      mstpTbl[tblAddr_q[6:0]] <= ivs_pkg::ivs_mstp_entry_t'(stageFlat[129:0]);
    end
  end

  // ****************************************************************
  // table lookup
  // ****************************************************************
  wire [12:0] vlanIdx = {req.xvidExt, req.ivid};
  wire vlanIdxOk = vlanIdx < 13'(ivs_pkg::VLAN_DEPTH);
  ivs_pkg::ivs_vlan_entry_t vlanRaw;
  ivs_pkg::ivs_vlan_entry_t vlanEnt;
  ivs_pkg::ivs_mstp_entry_t mstpEnt;
  assign vlanRaw = vlanIdxOk ? vlanTbl[vlanIdx] : '0;
  wire mstpPtrOk = vlanRaw.mstpPtr < 7'(ivs_pkg::MSTP_DEPTH);

  always_comb begin
    vlanEnt = '0;
    vlanEnt.portMask = {ivs_pkg::NPORT{1'b1}};
    mstpEnt.fwdMask = {ivs_pkg::NPORT{1'b1}};
    mstpEnt.lrnMask = {ivs_pkg::NPORT{1'b1}};
    if (vlanEna_q) begin
      vlanEnt = vlanRaw;
      mstpEnt = mstpPtrOk ? mstpTbl[vlanRaw.mstpPtr] : '0;
    end
  end

  // ****************************************************************
  // per-port decisions
  // ****************************************************************
  wire [6:0] pn = req.portNum;
  wire portOk = pn < 7'(ivs_pkg::NPORT);
  wire specialPort = (pn == ivs_pkg::CPU_PORT) | (pn == ivs_pkg::VIRT_DEV_PORT_ZERO) |
    (pn == ivs_pkg::VIRT_DEV_PORT_ONE);
  wire [64:0] portFwdMask = mask_q[ivs_pkg::BANK_PORT_FWD];
  wire [64:0] isoMask = mask_q[ivs_pkg::BANK_ISOLATED];
  wire [64:0] comMask = mask_q[ivs_pkg::BANK_COMMUNITY];
  wire portFwdOn = portOk & portFwdMask[pn];
  wire portLrnOn = portOk & mask_q[ivs_pkg::BANK_PORT_LRN][pn];
  wire filterOn = portOk & mask_q[ivs_pkg::BANK_IGR_FILTER][pn];
  wire isMember = portOk & vlanEnt.portMask[pn];
  wire treeFwd = portOk & mstpEnt.fwdMask[pn];
  wire treeLrn = portOk & mstpEnt.lrnMask[pn];
  wire checks = ~specialPort;
  wire lookupChecks = checks & vlanEna_q;
  wire filtered = lookupChecks & filterOn & ~isMember;
  wire treeStep = lookupChecks & ~filtered;
  wire pvlanStep = treeStep & vlanEnt.privateEna;

  logic [1:0] portType;
  always_comb begin
    portType = req.ingrPortType;
    if (pvlanStep && !req.stackHeaderPresent) begin
      portType = ivs_pkg::PTYPE_PROMISC;
      if (portOk && comMask[pn]) begin
        portType = ivs_pkg::PTYPE_COMMUNITY;
      end
      if (portOk && isoMask[pn]) begin
        portType = ivs_pkg::PTYPE_ISOLATED;
      end
    end
  end

  logic [64:0] memberMask;
  always_comb begin
    memberMask = vlanEnt.portMask;
    if (pvlanStep && portType == ivs_pkg::PTYPE_ISOLATED) begin
      memberMask = vlanEnt.portMask & ~isoMask & ~comMask;
    end else if (pvlanStep && portType == ivs_pkg::PTYPE_COMMUNITY) begin
      memberMask = vlanEnt.portMask & ~isoMask;
    end
  end

  // forward and learn decisions; a cleared decision never comes back
  wire fwdOut = req.l2Fwd & ~(checks & ~portFwdOn) & ~filtered & ~(treeStep & ~treeFwd)
    & ~(vlanEnt.secFwdEna & ~req.smacKnown);
  wire lrnOut = req.l2Lrn & checks & portLrnOn & ~filtered
    & ~(treeStep & (vlanEnt.lrnDis | ~treeLrn));

  // ****************************************************************
  // diagnostics
  // ****************************************************************
  wire live = req.valid & ~req.cpuInject;
  logic [ivs_pkg::NSTICKY-1:0] stickySet;
  always_comb begin
    stickySet = '0;
    stickySet[ivs_pkg::STK_PORT_FWD_DENY] = live & checks & ~portFwdOn;
    stickySet[ivs_pkg::STK_PORT_LRN_DENY] = live & checks & ~portLrnOn;
    stickySet[ivs_pkg::STK_VLAN_INVLD] = live & lookupChecks & (vlanEnt.portMask == '0);
    stickySet[ivs_pkg::STK_IGR_FILTER] = live & filtered;
    stickySet[ivs_pkg::STK_MSTP_DISCARD] = live & treeStep & ~treeFwd;
    stickySet[ivs_pkg::STK_MSTP_FWD_OK] = live & treeStep & treeFwd;
    stickySet[ivs_pkg::STK_VLAN_LRN_DENY] = live & treeStep & vlanEnt.lrnDis;
    stickySet[ivs_pkg::STK_MSTP_LRN_DENY] = live & treeStep & ~vlanEnt.lrnDis & ~treeLrn;
    stickySet[ivs_pkg::STK_MSTP_LRN_OK] = live & treeStep & ~vlanEnt.lrnDis & treeLrn;
  end

  // write one to clear; a frame event in the same cycle keeps the bit set
  wire [ivs_pkg::NSTICKY-1:0] stickyClr = wrSticky ? hwdata[ivs_pkg::NSTICKY-1:0] : '0;
  assign sticky_d = (sticky_q & ~stickyClr) | stickySet;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // ****************************************************************
  // result
  // ****************************************************************
  always_comb begin
    resp_d = '0;
    resp_d.valid = req.valid;
    resp_d.bypassed = req.cpuInject;
    resp_d.l2Fwd = req.l2Fwd;
    resp_d.l2Lrn = req.l2Lrn;
    resp_d.ingrPortType = req.ingrPortType;
    if (!req.cpuInject) begin
      resp_d.l2Fwd = fwdOut;
      resp_d.l2Lrn = lrnOut;
      resp_d.ingrPortType = portType;
      resp_d.vlanMask = memberMask & portFwdMask & mstpEnt.fwdMask;
      resp_d.ifid = vlanEnt.fid;
      resp_d.mirror = vlanEnt.mirrorEna;
      resp_d.floodDis = vlanEnt.floodDis;
      resp_d.secFwdEna = vlanEnt.secFwdEna;
      resp_d.evid = req.ivid;
      resp_d.efid = req.dmac[40] ? {1'b0, req.ivid} : vlanEnt.fid;
      resp_d.irleg = vlanEnt.routerLeg;
      resp_d.erleg = vlanEnt.routerLeg;
    end
  end

  // single-cycle stage: a new request is taken every cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resp_q <= '0;
      reqReady_q <= 1'b0;
    end else begin
      resp_q <= resp_d;
      reqReady_q <= 1'b1;
    end
  end
  assign resp = resp_q;
  assign reqReady = reqReady_q;
endmodule
`default_nettype wire

// ---- ivs_pkg.sv ----
/*
  Shared constants and carriers for the ingress VLAN / spanning-tree lookup stage:
  register offsets, sticky positions, table geometry, entry layouts, request and result.
  Assumes a single 50 MHz core clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package ivs_pkg;
  // ****************************************************************
  // table geometry
  // ****************************************************************
  localparam int NPORT = 65;
  localparam int VLAN_DEPTH = 5120;
  localparam int MSTP_DEPTH = 66;
  localparam int VID_EXT_STEP = 4096;
  localparam logic [6:0] CPU_PORT = 7'h41;
  localparam logic [6:0] VIRT_DEV_PORT_ZERO = 7'h42;
  localparam logic [6:0] VIRT_DEV_PORT_ONE = 7'h43;
  localparam logic [1:0] PTYPE_PROMISC = 2'h0;
  localparam logic [1:0] PTYPE_COMMUNITY = 2'h1;
  localparam logic [1:0] PTYPE_ISOLATED = 2'h2;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STICKY = 8'h04;
  localparam logic [7:0] REG_TBL_ADDR = 8'h08;
  localparam logic [7:0] REG_TBL_CMD = 8'h0C;
  localparam logic [7:0] REG_STAGE_BASE = 8'h10;
  localparam logic [7:0] REG_MASK_BASE = 8'h40;
  localparam int STAGE_WORDS = 5;
  localparam int MASK_BANKS = 5;
  localparam int MASK_WORDS = 3;
  localparam int MASK_BANK_STRIDE = 16;
  localparam int BANK_PORT_FWD = 0;
  localparam int BANK_PORT_LRN = 1;
  localparam int BANK_IGR_FILTER = 2;
  localparam int BANK_ISOLATED = 3;
  localparam int BANK_COMMUNITY = 4;
  localparam int CTRL_VLAN_ENA_BIT = 0;
  localparam logic CTRL_VLAN_ENA_RST = 1'b0;
  localparam int CMD_WR_VLAN_BIT = 0;
  localparam int CMD_WR_MSTP_BIT = 1;
  localparam int CMD_RD_VLAN_BIT = 2;
  localparam int CMD_RD_MSTP_BIT = 3;
  localparam logic [64:0] MASK_RST = 65'h0;

  // ****************************************************************
  // sticky bit positions
  // ****************************************************************
  localparam int NSTICKY = 9;
  localparam int STK_PORT_FWD_DENY = 0;
  localparam int STK_PORT_LRN_DENY = 1;
  localparam int STK_VLAN_INVLD = 2;
  localparam int STK_IGR_FILTER = 3;
  localparam int STK_MSTP_DISCARD = 4;
  localparam int STK_MSTP_FWD_OK = 5;
  localparam int STK_VLAN_LRN_DENY = 6;
  localparam int STK_MSTP_LRN_DENY = 7;
  localparam int STK_MSTP_LRN_OK = 8;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] updGroup;
    logic [64:0] portMask;
    logic mirrorEna;
    logic privateEna;
    logic rlegEna;
    logic lrnDis;
    logic floodDis;
    logic secFwdEna;
    logic [12:0] fid;
    logic [6:0] mstpPtr;
    logic [8:0] routerLeg;
  } ivs_vlan_entry_t;

  typedef struct packed {
    logic [64:0] lrnMask;
    logic [64:0] fwdMask;
  } ivs_mstp_entry_t;

  typedef struct packed {
    logic valid;
    logic cpuInject;
    logic [11:0] ivid;
    logic xvidExt;
    logic [6:0] portNum;
    logic [47:0] dmac;
    logic stackHeaderPresent;
    logic [1:0] ingrPortType;
    logic l2Fwd;
    logic l2Lrn;
    logic smacKnown;
  } ivs_req_t;

  typedef struct packed {
    logic valid;
    logic bypassed;
    logic l2Fwd;
    logic l2Lrn;
    logic [64:0] vlanMask;
    logic [12:0] ifid;
    logic [12:0] efid;
    logic [11:0] evid;
    logic mirror;
    logic floodDis;
    logic secFwdEna;
    logic [1:0] ingrPortType;
    logic [8:0] irleg;
    logic [8:0] erleg;
  } ivs_resp_t;
endpackage
`default_nettype wire

// ---- ivs_lookup_props.sv ----
/*
  Checker for the lookup stage: request/result timing and result relations.
  Assumes it is bound to the stage's top module and sees only its ports.
*/
`default_nettype none
module ivs_lookup_props (
  input wire logic mclk,
  input wire logic rst,
  input wire ivs_pkg::ivs_req_t req,
  input wire logic reqReady,
  input wire ivs_pkg::ivs_resp_t resp
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_one_per_req;
    req.valid && reqReady |=> resp.valid;
  endproperty
  a_one_per_req: assert property (p_one_per_req) else $error("request gave no result");
  property p_no_spurious;
    !req.valid |=> !resp.valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("result without request");
  property p_ready_stays;
    reqReady |=> reqReady;
  endproperty
  a_ready_stays: assert property (p_ready_stays) else $error("request ready dropped");
  property p_bypass;
    req.valid && req.cpuInject |=> resp.bypassed && resp.vlanMask == '0 && resp.l2Fwd == $past(req.l2Fwd);
  endproperty
  a_bypass: assert property (p_bypass) else $error("injected frame altered");
  property p_evid;
    req.valid && !req.cpuInject |=> resp.evid == $past(req.ivid);
  endproperty
  a_evid: assert property (p_evid) else $error("egress vid differs");
  property p_efid_mc;
    req.valid && !req.cpuInject && req.dmac[40] |=> resp.efid == {1'b0, $past(req.ivid)};
  endproperty
  a_efid_mc: assert property (p_efid_mc) else $error("multicast egress id wrong");
  property p_efid_uc;
    req.valid && !req.cpuInject && !req.dmac[40] |=> resp.efid == resp.ifid;
  endproperty
  a_efid_uc: assert property (p_efid_uc) else $error("unicast egress id wrong");
  property p_rleg;
    resp.valid && !resp.bypassed |-> resp.erleg == resp.irleg;
  endproperty
  a_rleg: assert property (p_rleg) else $error("router legs differ");
  property p_special;
    req.valid && !req.cpuInject && req.portNum >= ivs_pkg::CPU_PORT |=> !resp.l2Lrn;
  endproperty
  a_special: assert property (p_special) else $error("special port learned");

  c_bypass: cover property (req.valid && req.cpuInject);
  c_mcast: cover property (req.valid && req.dmac[40]);
  c_burst: cover property (req.valid ##1 req.valid);
endmodule

bind ivs_lookup ivs_lookup_props u_props (.mclk(mclk), .rst(rst), .req(req), .reqReady(reqReady), .resp(resp));
`default_nettype wire

// ---- ivs_upstream_model.sv ----
/*
  Upstream stage model: presents frame requests and collects results.
  Assumes the caller waits between clock edges; the result stands one cycle.
*/
`default_nettype none
module ivs_upstream_model (
  input wire logic mclk,
  output var ivs_pkg::ivs_req_t req,
  input wire ivs_pkg::ivs_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // request driver
  // ****************
  initial req = '0;

  // result sampled mid-cycle, after the answering edge has landed
  task automatic xfer(input ivs_pkg::ivs_req_t r, output ivs_pkg::ivs_resp_t o);
    @(posedge mclk) req <= r;
    @(posedge mclk) req.valid <= 1'b0;
    @(negedge mclk) o = resp;
  endtask

  task automatic xfer2(input ivs_pkg::ivs_req_t a, input ivs_pkg::ivs_req_t b,
                       output ivs_pkg::ivs_resp_t oa, output ivs_pkg::ivs_resp_t ob);
    @(posedge mclk) req <= a;
    @(posedge mclk) req <= b;
    @(negedge mclk) oa = resp;
    @(posedge mclk) req.valid <= 1'b0;
    @(negedge mclk) ob = resp;
  endtask
endmodule
`default_nettype wire

// ---- ivs_lookup_tb.sv ----
/*
  Self-checking bench for the lookup stage: register bus, tables and frame results.
  Assumes the upstream model file and the checker are compiled alongside.
*/
`default_nettype none
module ivs_lookup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, reqReady;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  ivs_pkg::ivs_req_t req, r, r2;
  ivs_pkg::ivs_resp_t resp, o, o2;
  ivs_pkg::ivs_vlan_entry_t ve;
  ivs_pkg::ivs_mstp_entry_t te;
  int failures = 0;
  int compares = 0;

  ivs_lookup dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .req(req), .reqReady(reqReady), .resp(resp));
  ivs_upstream_model up (.mclk(mclk), .req(req), .resp(resp));

  // ****************
  // helpers
  // ****************
  task automatic chk(input string n, input logic [64:0] e, input logic [64:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // one single transfer; hready is the slave's own hreadyout
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 65'h0, hresp);
  endtask

  task automatic stk(input logic [8:0] e);
    bus(1'b0, ivs_pkg::REG_STICKY, 32'h0);
    chk("sticky", e, rd);
    bus(1'b1, ivs_pkg::REG_STICKY, 32'h1FF);
  endtask

  task automatic msk(input int b, input logic [64:0] m);
    bus(1'b1, ivs_pkg::REG_MASK_BASE + 8'(16 * b), m[31:0]);
    bus(1'b1, ivs_pkg::REG_MASK_BASE + 8'(16 * b + 4), m[63:32]);
    bus(1'b1, ivs_pkg::REG_MASK_BASE + 8'(16 * b + 8), {31'h0, m[64]});
  endtask

  task automatic tbl(input logic [12:0] i, input logic [159:0] w, input int c);
    for (int k = 0; k < 5; k++) bus(1'b1, ivs_pkg::REG_STAGE_BASE + 8'(4 * k), w[32*k+:32]);
    bus(1'b1, ivs_pkg::REG_TBL_ADDR, {19'h0, i});
    bus(1'b1, ivs_pkg::REG_TBL_CMD, 32'(1 << c));
  endtask

  function automatic ivs_pkg::ivs_req_t mk(input logic [6:0] p, input logic [11:0] v, input logic x);
    mk = '0;
    mk.valid = 1'b1;
    mk.portNum = p;
    mk.ivid = v;
    mk.xvidExt = x;
    mk.l2Fwd = 1'b1;
    mk.l2Lrn = 1'b1;
    mk.smacKnown = 1'b1;
  endfunction

  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    bus(1'b0, ivs_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 65'h0, rd);
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 65'h0, rd);
    stk(9'h0);
  endtask

  // lookup off; port masks cleared, then forward and learn masks set to all ones
  task automatic t_default;
    for (int p = 65; p < 68; p++) begin
      up.xfer(mk(7'(p), 12'h1, 1'b0), o);
      chk("special", 65'h2, {o.l2Fwd, o.l2Lrn});
    end
    r = mk(7'd3, 12'h5, 1'b0);
    r.cpuInject = 1'b1;
    r.l2Lrn = 1'b0;
    r.ingrPortType = 2'h1;
    up.xfer(r, o);
    chk("bypass", {1'b1, 1'b1, 1'b0, 2'h1, 65'h0}, {o.bypassed, o.l2Fwd, o.l2Lrn, o.ingrPortType, o.vlanMask});
    stk(9'h0);
    up.xfer(mk(7'd3, 12'h5, 1'b0), o);
    chk("denied", 65'h0, {o.l2Fwd, o.l2Lrn, o.vlanMask});
    stk(9'h003);
    msk(ivs_pkg::BANK_PORT_FWD, {65{1'b1}});
    msk(ivs_pkg::BANK_PORT_LRN, {65{1'b1}});
    up.xfer(mk(7'd64, 12'h5, 1'b0), o);
    chk("defmask", {65{1'b1}}, o.vlanMask);
    chk("defflags", 65'h3, {o.ifid, o.mirror, o.irleg, o.l2Fwd, o.l2Lrn});
    stk(9'h0);
  endtask

  task automatic t_chain;
    ve = '0;
    ve.routerLeg = 9'h1A5;
    ve.mstpPtr = 7'd65;
    ve.fid = 13'h1ABC;
    ve.floodDis = 1'b1;
    ve.mirrorEna = 1'b1;
    ve.portMask = 65'h1408;
    ve.updGroup = 16'hFFFF;
    tbl(13'd4101, 160'(ve), ivs_pkg::CMD_WR_VLAN_BIT);
    te.fwdMask = 65'h43E;
    te.lrnMask = 65'h8;
    tbl(13'd65, 160'(te), ivs_pkg::CMD_WR_MSTP_BIT);
    tbl(13'd0, 160'h0, ivs_pkg::CMD_WR_MSTP_BIT);
    bus(1'b1, ivs_pkg::REG_CTRL, 32'h1);
    r = mk(7'd3, 12'h005, 1'b1);
    r2 = r;
    r2.dmac[40] = 1'b1;
    r2.portNum = 7'd12;
    up.xfer2(r, r2, o, o2);
    chk("mask", 65'h408, o.vlanMask);
    chk("ifid", 13'h1ABC, o.ifid);
    chk("efid", 13'h1ABC, o.efid);
    chk("rleg", {9'h1A5, 9'h1A5}, {o.irleg, o.erleg});
    chk("flags", 65'h6, {o.mirror, o.floodDis, o.secFwdEna});
    chk("fwdlrn", 65'h3, {o.l2Fwd, o.l2Lrn});
    chk("mcefid", 65'h005, o2.efid);
    chk("discard", 65'h0, {o2.l2Fwd, o2.l2Lrn});
    stk(9'h1B0);
    up.xfer(mk(7'd3, 12'hFFF, 1'b1), o);
    chk("empty", 65'h0, o.vlanMask);
    stk(9'h094);
    msk(ivs_pkg::BANK_IGR_FILTER, 65'h10);
    up.xfer(mk(7'd4, 12'h005, 1'b1), o);
    chk("filter", 65'h0, {o.l2Fwd, o.l2Lrn});
    stk(9'h008);
  endtask

  task automatic t_private;
    logic [6:0] pp [4] = '{7'd2, 7'd3, 7'd5, 7'd2};
    logic [1:0] pt [4] = '{2'h2, 2'h1, 2'h0, 2'h1};
    logic [64:0] em [4] = '{65'h30, 65'h38, 65'h3E, 65'h38};
    ve.privateEna = 1'b1;
    ve.lrnDis = 1'b1;
    ve.secFwdEna = 1'b1;
    ve.portMask = 65'h3E;
    tbl(13'd20, 160'(ve), ivs_pkg::CMD_WR_VLAN_BIT);
    msk(ivs_pkg::BANK_ISOLATED, 65'h6);
    msk(ivs_pkg::BANK_COMMUNITY, 65'hC);
    for (int k = 0; k < 4; k++) begin
      r = mk(pp[k], 12'd20, 1'b0);
      r.stackHeaderPresent = (k == 3);
      r.ingrPortType = 2'h1;
      r.smacKnown = (k != 0);
      up.xfer(r, o);
      chk("ptype", pt[k], o.ingrPortType);
      chk("pvmask", em[k], o.vlanMask);
      chk("secfwd", 65'(k != 0), o.l2Fwd);
      chk("lrndis", 65'h0, o.l2Lrn);
    end
    stk(9'h060);
    bus(1'b1, ivs_pkg::REG_TBL_CMD, 32'(1 << ivs_pkg::CMD_RD_VLAN_BIT));
    bus(1'b0, ivs_pkg::REG_STAGE_BASE, 32'h0);
    chk("vlanrd", {33'h0, ve[31:0]}, rd);
    bus(1'b1, ivs_pkg::REG_TBL_ADDR, 32'd65);
    bus(1'b1, ivs_pkg::REG_TBL_CMD, 32'(1 << ivs_pkg::CMD_RD_MSTP_BIT));
    bus(1'b0, ivs_pkg::REG_STAGE_BASE, 32'h0);
    chk("mstprd", {33'h0, te.fwdMask[31:0]}, rd);
  endtask

  // ****************
  // run control
  // ****************
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // whole run needs 67 bus transfers, well under this span
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_default();
    t_chain();
    t_private();
    tally_and_finish();
  end
endmodule
`default_nettype wire
